// File: rtl/activation_ctrl.sv
// Reader-side control of card activation after anticollision.
//
// Overview of operation
// - Send E0 01 plus CRC_A, await answer.
// - On silence, optionally resend request once.
// - No valid answer at all: send DESELECT.
// - Bad CRC_A answer counts as no answer.
// - Valid answer: report result code to host.
// - No TA: I-block after next host command.
// - Valid answer after resend: continue normally.
// - Parameter selection only when reader enables it.
// - TA not 00 allows parameter selection exchange.
// - Bad selection answer: resend or continue, default rate.
`timescale 1ns/1ps
`include "act_defs.svh"

module activation_ctrl
   import act_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = `ACT_TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   input wire logic retry_en_i,
   input wire logic pps_en_i,
   input wire logic host_cmd_i,
   input wire rx_frame_t rx_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output tx_byte_t tx_o,
   output logic result_valid_o,
   output result_code_t result_code_o,
   output logic busy_o,
   output logic active_o,
   output logic pps_done_o
);

   localparam int TW = $clog2(TIMEOUT_CYC + 1);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************

   if (TIMEOUT_CYC < 2) begin : g_bad_timeout
      $error("TIMEOUT_CYC must be at least 2");
   end

   // ****************************************************************
   // Frame tables
   // ****************************************************************

   // Payload length of each frame, checksum excluded.
   function automatic logic [2:0] frame_len(input frame_kind_t k);
      unique case (k)
         FR_RATS: frame_len = 3'd2;
         FR_PPS: frame_len = 3'd3;
         default: frame_len = 3'd1;
      endcase
   endfunction : frame_len

   // Payload byte at a given position of each frame.
   function automatic logic [7:0] frame_byte(input frame_kind_t k,
                                             input logic [2:0] i);
      unique case (k)
         FR_RATS: frame_byte = (i == 3'd0) ? `ACT_RATS_B0 : `ACT_RATS_B1;
         FR_PPS: frame_byte = (i == 3'd0) ? `ACT_PPS_B0 :
                              (i == 3'd1) ? `ACT_PPS_B1 : `ACT_PPS_B2;
         FR_IBLK: frame_byte = `ACT_IBLK_PCB;
         default: frame_byte = `ACT_DESEL_PCB;
      endcase
   endfunction : frame_byte

   // ****************************************************************
   // Declarations
   // ****************************************************************

   act_state_t state_r, state_nxt;
   frame_kind_t kind_r, kind_nxt;
   logic retried_r, retried_nxt;
   logic send_start;
   logic [2:0] idx_r;
   logic [2:0] len;
   logic fire;
   logic [15:0] tx_crc, tx_crc_upd, rx_crc;
   logic [3:0] rx_cnt_r;
   logic t0_ta_r;
   logic ta_nz_r;
   logic [TW-1:0] wait_cnt_r;
   logic timeout;
   logic ans_end;
   logic ans_good;
   logic res_set;
   result_code_t res_code;
   logic pps_ok_set;
   logic act_set;

   assign len = frame_len(kind_r);
   assign fire = tx_valid_o & tx_ready_i;
   assign busy_o = (state_r != ST_IDLE);
   assign tx_valid_o = (state_r == ST_SEND);

   // ****************************************************************
   // Checksum engines
   // ****************************************************************

   // Transmit side sums payload bytes only, not the appended checksum.
   crc_a_calc u_tx_crc (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .clear_i(send_start),
      .en_i(fire && (idx_r < len)),
      .data_i(tx_o.data),
      .crc_o(tx_crc),
      .crc_upd_o(tx_crc_upd)
   );

   // Receive side sums every byte; an intact frame leaves the residue.
   crc_a_calc u_rx_crc (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .clear_i(send_start),
      .en_i(rx_i.valid && (state_r == ST_WAIT)),
      .data_i(rx_i.data),
      .crc_o(rx_crc),
      .crc_upd_o()
   );

   // ****************************************************************
   // Answer evaluation
   // ****************************************************************

   // Silence and a corrupt frame give the same verdict.
   assign timeout = (wait_cnt_r == TW'(TIMEOUT_CYC - 1));
   assign ans_end = (state_r == ST_WAIT) && (rx_i.done || timeout);
   assign ans_good = rx_i.done && !timeout &&
                     (rx_crc == `ACT_CRC_RESIDUE) &&
                     (rx_cnt_r >= `ACT_MIN_ANS_LEN);

   // ****************************************************************
   // Sequencer
   // ****************************************************************

   // Next state, frame choice and retry bookkeeping.
   always_comb begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      retried_nxt = retried_r;
      send_start = 1'b0;
      res_set = 1'b0;
      res_code = RES_NONE;
      pps_ok_set = 1'b0;
      act_set = 1'b0;
      unique case (state_r)
         ST_IDLE: begin
            if (start_i) begin
               kind_nxt = FR_RATS;
               retried_nxt = 1'b0;
               send_start = 1'b1;
               state_nxt = ST_SEND;
            end
         end
         ST_SEND: begin
            if (fire && tx_o.last) begin
               if (kind_r == FR_RATS || kind_r == FR_PPS) begin
                  state_nxt = ST_WAIT;
               end else begin
                  act_set = (kind_r == FR_IBLK);
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_WAIT: begin
            if (ans_end) begin
               if (kind_r == FR_RATS) begin
                  if (ans_good) begin
                     // Same path whether or not a resend was needed.
                     res_set = 1'b1;
                     res_code = ta_nz_r ? RES_OK_TA : RES_OK;
                     state_nxt = ST_HOLD;
                  end else if (retry_en_i && !retried_r) begin
                     retried_nxt = 1'b1;
                     send_start = 1'b1;
                     state_nxt = ST_SEND;
                  end else begin
                     res_set = 1'b1;
                     res_code = RES_FAIL;
                     kind_nxt = FR_DESEL;
                     send_start = 1'b1;
                     state_nxt = ST_SEND;
                  end
               end else begin
                  // A failed selection never changes the rate.
                  if (ans_good) begin
                     pps_ok_set = 1'b1;
                     state_nxt = ST_HOLD;
                  end else if (!retried_r) begin
                     retried_nxt = 1'b1;
                     send_start = 1'b1;
                     state_nxt = ST_SEND;
                  end else begin
                     state_nxt = ST_HOLD;
                  end
               end
            end
         end
         ST_HOLD: begin
            if (pps_en_i && ta_nz_r && kind_r == FR_RATS) begin
               kind_nxt = FR_PPS;
               retried_nxt = 1'b0;
               send_start = 1'b1;
               state_nxt = ST_SEND;
            end else if (host_cmd_i) begin
               kind_nxt = FR_IBLK;
               send_start = 1'b1;
               state_nxt = ST_SEND;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= ST_IDLE;
         kind_r <= FR_RATS;
         retried_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         retried_r <= retried_nxt;
      end
   end

   // ****************************************************************
   // Transmit byte path
   // ****************************************************************

   // Checksum goes out low byte first after the payload. The low byte
   // uses the combinational update so no idle cycle is spent on it.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         idx_r <= 3'd0;
         tx_o <= '0;
      end else if (send_start) begin
         idx_r <= 3'd0;
         tx_o.data <= frame_byte(kind_nxt, 3'd0);
         tx_o.last <= 1'b0;
      end else if (fire && !tx_o.last) begin
         idx_r <= idx_r + 3'd1;
         if (idx_r + 3'd1 < len) begin
            tx_o.data <= frame_byte(kind_r, idx_r + 3'd1);
         end else if (idx_r + 3'd1 == len) begin
            tx_o.data <= tx_crc_upd[7:0];
         end else begin
            tx_o.data <= tx_crc[15:8];
            tx_o.last <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Receive capture and response timer
   // ****************************************************************

   // Byte count and the bit-rate byte of the answer.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_cnt_r <= 4'h0;
         t0_ta_r <= 1'b0;
         ta_nz_r <= 1'b0;
      end else if (send_start) begin
         rx_cnt_r <= 4'h0;
         t0_ta_r <= 1'b0;
         if (kind_nxt == FR_RATS) begin
            ta_nz_r <= 1'b0;
         end
      end else if (rx_i.valid && state_r == ST_WAIT && kind_r == FR_RATS) begin
         if (rx_cnt_r != 4'hF) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
         end
         if (rx_cnt_r == 4'h1) begin
            t0_ta_r <= rx_i.data[`ACT_T0_TA_BIT];
         end
         if (rx_cnt_r == 4'h2 && t0_ta_r) begin
            ta_nz_r <= (rx_i.data != `ACT_TA_NONE);
         end
      end else if (rx_i.valid && state_r == ST_WAIT && rx_cnt_r != 4'hF) begin
         rx_cnt_r <= rx_cnt_r + 4'h1;
      end
   end

   // Timer runs only while an answer is awaited.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_cnt_r <= '0;
      end else if (state_r != ST_WAIT || ans_end) begin
         wait_cnt_r <= '0;
      end else begin
         wait_cnt_r <= wait_cnt_r + TW'(1);
      end
   end

   // ****************************************************************
   // Host-facing outcome
   // ****************************************************************

   // Result pulse and sticky status; a new activation clears them.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_valid_o <= 1'b0;
         result_code_o <= RES_NONE;
         active_o <= 1'b0;
         pps_done_o <= 1'b0;
      end else begin
         result_valid_o <= res_set;
         if (res_set) begin
            result_code_o <= res_code;
         end
         if (state_r == ST_IDLE && start_i) begin
            active_o <= 1'b0;
            pps_done_o <= 1'b0;
         end else begin
            active_o <= active_o | act_set;
            pps_done_o <= pps_done_o | pps_ok_set;
         end
      end
   end

endmodule : activation_ctrl

// File: rtl/act_defs.svh
// Constant definitions for the reader card activation controller.
`ifndef ACT_DEFS_SVH
`define ACT_DEFS_SVH

// ****************************************************************
// Frame contents
// ****************************************************************
`define ACT_RATS_B0 8'hE0
`define ACT_RATS_B1 8'h01
`define ACT_DESEL_PCB 8'hC2
`define ACT_IBLK_PCB 8'h02
`define ACT_PPS_B0 8'hD0
`define ACT_PPS_B1 8'h11
`define ACT_PPS_B2 8'h00

// ****************************************************************
// Answer layout and checksum
// ****************************************************************
`define ACT_T0_TA_BIT 4
`define ACT_TA_NONE 8'h00
`define ACT_MIN_ANS_LEN 4'h3
`define ACT_CRC_INIT 16'h6363
`define ACT_CRC_POLY 16'h8408
`define ACT_CRC_RESIDUE 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define ACT_CLK_MHZ 200
`define ACT_RESP_TIMEOUT_US 5000
`define ACT_TIMEOUT_CYC (`ACT_RESP_TIMEOUT_US * `ACT_CLK_MHZ)

`endif

// File: rtl/act_pkg.sv
// Types shared by the reader card activation controller.
package act_pkg;

   // Byte offered to the frame transmitter.
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } tx_byte_t;

   // Byte or end marker from the frame receiver.
   typedef struct packed {
      logic valid;
      logic done;
      logic [7:0] data;
   } rx_frame_t;

   typedef enum logic [3:0] {
      FR_RATS = 4'b0001,
      FR_PPS = 4'b0010,
      FR_IBLK = 4'b0100,
      FR_DESEL = 4'b1000
   } frame_kind_t;

   typedef enum logic [1:0] {
      RES_NONE = 2'h0,
      RES_OK = 2'h1,
      RES_OK_TA = 2'h2,
      RES_FAIL = 2'h3
   } result_code_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SEND = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_HOLD = 4'b1000
   } act_state_t;

endpackage : act_pkg

// File: rtl/crc_a_calc.sv
// Byte-serial CRC_A checksum register.
`timescale 1ns/1ps
`include "act_defs.svh"

module crc_a_calc (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic clear_i,
   input wire logic en_i,
   input wire logic [7:0] data_i,
   output logic [15:0] crc_o,
   output logic [15:0] crc_upd_o
);

   // ****************************************************************
   // Next value
   // ****************************************************************

   // One byte, LSB first, through the reflected polynomial.
   always_comb begin
      logic [15:0] c;
      c = crc_o ^ {8'h00, data_i};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `ACT_CRC_POLY) : (c >> 1);
      end
      crc_upd_o = c;
   end

   // ****************************************************************
   // Register
   // ****************************************************************

   // Clear wins so a new frame never inherits old bytes.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         crc_o <= `ACT_CRC_INIT;
      end else if (clear_i) begin
         crc_o <= `ACT_CRC_INIT;
      end else if (en_i) begin
         crc_o <= crc_upd_o;
      end
   end

endmodule : crc_a_calc

// File: tb/activation_ctrl_chk.sv
// Port-level assertions for the activation controller.
`timescale 1ns/1ps
`include "act_defs.svh"
module activation_ctrl_chk
   import act_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = 50
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   input wire logic pps_en_i,
   input wire logic tx_ready_i,
   input wire logic tx_valid_o,
   input wire tx_byte_t tx_o,
   input wire logic result_valid_o,
   input wire result_code_t result_code_o,
   input wire logic busy_o,
   input wire logic active_o,
   input wire logic pps_done_o
);
   localparam int unsigned LIM = TIMEOUT_CYC + 4;
   logic in_frame_r;
   logic [7:0] head_r;
   int unsigned wait_r;
   logic take;
   assign take = tx_valid_o && tx_ready_i;
   // Remember the opening byte of the frame now on the link.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         in_frame_r <= 1'b0;
         head_r <= 8'h00;
      end else if (take) begin
         in_frame_r <= !tx_o.last;
         if (!in_frame_r) begin
            head_r <= tx_o.data;
         end
      end
   end
   // Count idle cycles after a request; a stuck wait must not hang.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_r <= 0;
      end else if (take && tx_o.last && head_r == `ACT_RATS_B0) begin
         wait_r <= 1;
      end else if (result_valid_o || tx_valid_o) begin
         wait_r <= 0;
      end else if (wait_r != 0) begin
         wait_r <= wait_r + 1;
      end
   end
   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_o)) else $error("tx byte dropped early");
   AST_START: assert property (!busy_o && start_i |=> tx_valid_o &&
      tx_o.data == 8'hE0 && !tx_o.last) else $error("request not E0");
   AST_RATS_B1: assert property (take && !in_frame_r &&
      tx_o.data == 8'hE0 |=> tx_valid_o && tx_o.data == 8'h01)
      else $error("second request byte wrong");
   AST_IDLE: assert property (!busy_o |-> !tx_valid_o)
      else $error("sending while idle");
   AST_RES_PULSE: assert property (result_valid_o |=> !result_valid_o)
      else $error("result pulse too long");
   AST_DESEL: assert property (result_valid_o &&
      result_code_o == RES_FAIL |-> ##[0:3] (tx_valid_o && !in_frame_r &&
      tx_o.data == `ACT_DESEL_PCB)) else $error("no deselect after fail");
   AST_NO_TA: assert property (result_valid_o &&
      result_code_o == RES_OK |-> !tx_valid_o [*4])
      else $error("frame sent without host command");
   AST_PPS_GATE: assert property (tx_valid_o && !in_frame_r &&
      tx_o.data == `ACT_PPS_B0 |-> pps_en_i)
      else $error("selection sent while disabled");
   AST_IBLK: assert property ($rose(active_o) |->
      head_r == `ACT_IBLK_PCB) else $error("active without block");
   AST_TIMEOUT: assert property (wait_r <= LIM)
      else $error("answer wait not bounded");
   cover property (result_valid_o && result_code_o == RES_FAIL);
   cover property (result_valid_o && result_code_o == RES_OK_TA);
   cover property ($rose(pps_done_o));
endmodule : activation_ctrl_chk

// File: tb/card_model.sv
// Behavioural proximity card that answers the reader's frames.
`timescale 1ns/1ps
module card_model
   import act_pkg::*;
(
   input wire logic clk_i,
   input wire logic tx_valid_i,
   input wire tx_byte_t tx_i,
   input wire logic slow_i,
   output logic tx_ready_o,
   output rx_frame_t rx_o
);
   // Answer kinds: 0 mute, 1 bad checksum, 2 no TA, 3 with TA, 4 PPS.
   int plan[$];
   logic [7:0] heads[$];
   logic [7:0] fr[$];
   int crc_bad = 0;
   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'h6363;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
      end
      return c;
   endfunction : crc
   // Released data lines show an inverted byte, never a stale one.
   task automatic answer();
      logic [7:0] a[$];
      logic [15:0] c;
      int k;
      if (crc(fr) != 16'h0000) crc_bad++;
      heads.push_back(fr[0]);
      fr = {};
      k = plan.size() > 0 ? plan.pop_front() : 0;
      if (k == 0) return;
      case (k)
         3: a = '{8'h03, 8'h10, 8'h11};
         4: a = '{8'hD0};
         default: a = '{8'h02, 8'h00};
      endcase
      c = crc(a);
      if (k == 1) c = ~c;
      a.push_back(c[7:0]);
      a.push_back(c[15:8]);
      repeat (slow_i ? 7 : 2) @(posedge clk_i);
      foreach (a[i]) begin
         rx_o <= {1'b1, 1'b0, a[i]};
         @(posedge clk_i);
      end
      rx_o <= {1'b0, 1'b1, 8'hA5};
      @(posedge clk_i);
      rx_o <= {1'b0, 1'b0, 8'h5A};
   endtask : answer
   // Sample at the falling edge so the taken byte is the settled one.
   initial begin
      logic tk;
      tx_byte_t b;
      tx_ready_o = 1'b0;
      rx_o = '0;
      forever begin
         @(negedge clk_i);
         tk = tx_valid_i && tx_ready_o;
         b = tx_i;
         @(posedge clk_i);
         tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
         fr.push_back(b.data);
         if (!tk) fr.pop_back();
         if (tk && b.last) answer();
      end
   end
endmodule : card_model

// File: tb/testbench.sv
// Self-checking bench for the activation controller.
`timescale 1ns/1ps
module testbench;
   import act_pkg::*;
   localparam int unsigned TO = 50;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic start_i = 1'b0;
   logic retry_en_i = 1'b0;
   logic pps_en_i = 1'b0;
   logic host_cmd_i = 1'b0;
   logic slow = 1'b0;
   logic tx_ready, tx_valid, res_valid, busy, active, pps_done;
   rx_frame_t rx;
   tx_byte_t tx;
   result_code_t code;
   result_code_t got_code = RES_NONE;
   int err_count = 0;
   int num_checks = 0;
   // The clock toggles every half period of 2.5 ns.
   always #2.5 clk_i = !clk_i;
   // Keep the last reported result; a new start forgets the old one.
   // One process owns the variable so no two drivers race on it.
   always @(posedge clk_i) begin
      if (res_valid) begin
         got_code <= code;
      end else if (start_i) begin
         got_code <= RES_NONE;
      end
   end
   activation_ctrl #(.TIMEOUT_CYC(TO)) DUT (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .start_i(start_i), .retry_en_i(retry_en_i),
      .pps_en_i(pps_en_i), .host_cmd_i(host_cmd_i), .rx_i(rx),
      .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_o(tx),
      .result_valid_o(res_valid), .result_code_o(code), .busy_o(busy),
      .active_o(active), .pps_done_o(pps_done));
   card_model card (.clk_i(clk_i), .tx_valid_i(tx_valid), .tx_i(tx),
      .slow_i(slow), .tx_ready_o(tx_ready), .rx_o(rx));
   task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_v
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   // A negative count waits for idle, otherwise for that many frames.
   task automatic wait_on(input int nb);
      int n;
      n = 0;
      while (nb < 0 ? busy !== 1'b0 : card.heads.size() < nb) begin
         @(negedge clk_i);
         n++;
         if (n > 5000) begin
            err_count++;
            give_verdict();
         end
      end
   endtask : wait_on
   task automatic act(input logic r, input logic p, input int nb);
      @(posedge clk_i);
      card.heads = {};
      retry_en_i <= r;
      pps_en_i <= p;
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
      wait_on(nb);
   endtask : act
   // Wait past any answer timeout so the block has settled in hold.
   task automatic host();
      repeat (TO + 30) @(posedge clk_i);
      host_cmd_i <= 1'b1;
      @(posedge clk_i);
      host_cmd_i <= 1'b0;
      @(posedge clk_i);
      wait_on(-1);
   endtask : host
   task automatic fin(input logic [7:0] e[$], input result_code_t c,
      input logic a, input logic p);
      chk_v(8'(card.heads.size()), 8'(e.size()));
      foreach (e[i]) chk_v(card.heads[i], e[i]);
      chk_v({6'h00, got_code}, {6'h00, c});
      chk_v({7'h00, active}, {7'h00, a});
      chk_v({7'h00, pps_done}, {7'h00, p});
      chk_v(8'(card.crc_bad), 8'h00);
   endtask : fin
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic s_mute();
      card.plan = '{0, 0};
      act(1'b1, 1'b0, 3);
      wait_on(-1);
      fin('{8'hE0, 8'hE0, 8'hC2}, RES_FAIL, 1'b0, 1'b0);
   endtask : s_mute
   task automatic s_badcrc();
      card.plan = '{1, 1};
      act(1'b1, 1'b0, 3);
      wait_on(-1);
      fin('{8'hE0, 8'hE0, 8'hC2}, RES_FAIL, 1'b0, 1'b0);
   endtask : s_badcrc
   task automatic s_noretry();
      slow <= 1'b1;
      card.plan = '{1};
      act(1'b0, 1'b0, 2);
      wait_on(-1);
      slow <= 1'b0;
      fin('{8'hE0, 8'hC2}, RES_FAIL, 1'b0, 1'b0);
   endtask : s_noretry
   task automatic s_plain();
      card.plan = '{2};
      act(1'b0, 1'b1, 1);
      host();
      fin('{8'hE0, 8'h02}, RES_OK, 1'b1, 1'b0);
   endtask : s_plain
   task automatic s_retry_pps();
      card.plan = '{0, 3, 1, 1};
      act(1'b1, 1'b1, 4);
      host();
      fin('{8'hE0, 8'hE0, 8'hD0, 8'hD0, 8'h02}, RES_OK_TA, 1'b1, 1'b0);
   endtask : s_retry_pps
   // Corrupt first answer, then two silent selection answers.
   task automatic s_retry_mute();
      card.plan = '{1, 3, 0, 0};
      act(1'b1, 1'b1, 4);
      host();
      fin('{8'hE0, 8'hE0, 8'hD0, 8'hD0, 8'h02}, RES_OK_TA, 1'b1, 1'b0);
   endtask : s_retry_mute
   task automatic s_pps_ok();
      card.plan = '{3, 4};
      act(1'b0, 1'b1, 2);
      host();
      fin('{8'hE0, 8'hD0, 8'h02}, RES_OK_TA, 1'b1, 1'b1);
   endtask : s_pps_ok
   task automatic s_no_pps();
      card.plan = '{3};
      act(1'b0, 1'b0, 1);
      host();
      fin('{8'hE0, 8'h02}, RES_OK_TA, 1'b1, 1'b0);
   endtask : s_no_pps
   // Reset for five cycles, then run every scenario in turn.
   initial begin
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      chk_v({6'h00, code}, 8'h00);
      chk_v({4'h0, busy, tx_valid, active, pps_done}, 8'h00);
      s_mute();
      s_badcrc();
      s_noretry();
      s_plain();
      s_retry_pps();
      s_retry_mute();
      s_pps_ok();
      s_no_pps();
      give_verdict();
   end
endmodule : testbench
bind activation_ctrl activation_ctrl_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
   .pps_en_i(pps_en_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
   .tx_o(tx_o), .result_valid_o(result_valid_o),
   .result_code_o(result_code_o), .busy_o(busy_o), .active_o(active_o),
   .pps_done_o(pps_done_o));
